// ### hw/usp_regs.svh
// Constants for the status, power indication and bus sharing block
`ifndef USP_REGS_SVH
`define USP_REGS_SVH
`define USP_CLK_HZ          40000000
`define USP_BLINK_HALF_MS   250
`define USP_BLINK_HALF_CYC  ((`USP_CLK_HZ / 1000) * `USP_BLINK_HALF_MS)
`define USP_ROM_SPACE_BYTES 4096
`define USP_DESC_MAX_BYTES  512
`define USP_SIG_LSB         8'h52
`define USP_SIG_MSB         8'h48
`define USP_CFG_OFS         32'h0000_0000
`define USP_STAT_OFS        32'h0000_0004
`define USP_ID_OFS          32'h0000_0008
`define USP_CFG_ENUM_BIT    0
`define USP_CFG_PU_BIT      1
`define USP_CFG_LOWPWR_BIT  2
`endif

// ### hw/usp_pkg.sv
// Types for the status, power indication and bus sharing block
package usp_pkg;
  typedef enum logic [1:0] {
    USP_SRC_ONBOARD = 2'b00,
    USP_SRC_SERIAL  = 2'b01,
    USP_SRC_DRIVE   = 2'b11
  } usp_src_e;

  typedef enum logic [1:0] {
    USP_ST_BOOT = 2'b00,
    USP_ST_RUN  = 2'b01
  } usp_state_e;

  typedef struct packed {
    usp_state_e   state;
    usp_src_e     src;
    logic         mode_latched;
    logic [24:0]  blink_cnt;
    logic         blink;
    logic         led_oe_n;
    logic         full_oe_n;
    logic         low_oe_n;
    logic         enum_pwr;
    logic         pu_oe_n;
    logic         ata_oe_n;
    logic         usb_en;
    logic         bus_powered;
    logic         enum_ctl;
    logic         pu_ctl;
    logic         low_ctl;
    logic         waitreq;
    logic [31:0]  rdata;
  } usp_state_s;
endpackage

// ### hw/usp_status_power.sv
// Status indicator, bus power indication, bus sharing and config source select
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`include "usp_regs.svh"
module usp_status_power
  import usp_pkg::*;
#(
  parameter int unsigned BLINK_HALF_CYC = `USP_BLINK_HALF_CYC,
  parameter logic [31:0] BLOCK_ID       = 32'h0000_A5C3
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  usb_config_value,
  input  wire logic        usb_suspended,
  input  wire logic        drive_bus_share_enable,
  input  wire logic        bus_power_in,
  input  wire logic        drive_cfg_mode,
  input  wire logic        serial_mem_present,
  input  wire logic        serial_sig_ok,
  input  wire logic        probe_done,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             led_out,
  output logic             led_oe_n,
  output logic             full_bus_power_grant_n,
  output logic             full_bus_power_grant_oe_n,
  output logic             low_bus_power_avail,
  output logic             low_bus_power_avail_oe_n,
  output logic             usb_enum_pwr,
  output logic             flow_ctl_pullup_drive,
  output logic             flow_ctl_pullup_oe_n,
  output logic             ata_out_oe_n,
  output logic             usb_if_enable,
  output logic             drive_bus_powered,
  output usp_src_e         cfg_source
);

  usp_state_s q;
  usp_state_s d;
  logic [31:0] byte_addr;
  logic        cfg_set;

  assign byte_addr = {26'h0, avs_address, 2'b00};
  assign cfg_set   = (usb_config_value != 8'h00);

  always_comb begin
    d = q;
    // Source decided once, on the first probe completion after reset
    // Serial source spans up to 4 Kbytes, descriptors within 512 bytes
    if (q.state == USP_ST_BOOT && probe_done) begin
      d.state        = USP_ST_RUN;
      d.mode_latched = drive_cfg_mode;
      if (serial_mem_present && !drive_cfg_mode && serial_sig_ok) begin
        d.src = USP_SRC_SERIAL;
      end else if (!serial_mem_present && drive_cfg_mode) begin
        d.src = USP_SRC_DRIVE;
      end else begin
        d.src = USP_SRC_ONBOARD;
      end
    end
    if (q.blink_cnt >= 25'(BLINK_HALF_CYC - 1)) begin
      d.blink_cnt = 25'h0;
      d.blink     = ~q.blink;
    end else begin
      d.blink_cnt = q.blink_cnt + 25'h1;
    end
    if (usb_suspended) begin
      d.led_oe_n = 1'b1;
    end else if (!cfg_set) begin
      d.led_oe_n = ~q.blink;
    end else begin
      d.led_oe_n = 1'b0;
    end
    d.full_oe_n   = ~cfg_set;
    // Low power is always available unsuspended; software can withhold it
    d.low_oe_n    = ~(!usb_suspended && q.low_ctl);
    d.bus_powered = bus_power_in;
    d.ata_oe_n    = ~drive_bus_share_enable;
    d.usb_en      = drive_bus_share_enable;
    d.enum_pwr    = q.enum_ctl && drive_bus_share_enable;
    d.pu_oe_n     = ~(q.pu_ctl && drive_bus_share_enable);
    // Avalon slave: one wait cycle, answer on the following edge
    d.waitreq = 1'b1;
    if ((avs_read || avs_write) && q.waitreq) begin
      d.waitreq = 1'b0;
      d.rdata   = 32'h0;
      if (avs_read) begin
        case (byte_addr)
          `USP_CFG_OFS:  d.rdata = {29'h0, q.low_ctl, q.pu_ctl, q.enum_ctl};
          `USP_STAT_OFS: d.rdata = {22'h0, q.src, q.state, q.mode_latched, q.bus_powered,
                                    q.usb_en, ~q.led_oe_n, ~q.full_oe_n, ~q.low_oe_n};
          `USP_ID_OFS:   d.rdata = BLOCK_ID;
          default:       d.rdata = 32'h0;
        endcase
      end
    end
    // Write lands at the edge where the master samples waitrequest low
    if (avs_write && !q.waitreq && byte_addr == `USP_CFG_OFS) begin
      d.enum_ctl = avs_writedata[`USP_CFG_ENUM_BIT];
      d.pu_ctl   = avs_writedata[`USP_CFG_PU_BIT];
      d.low_ctl  = avs_writedata[`USP_CFG_LOWPWR_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q         <= '0;
      q.state   <= USP_ST_BOOT;
      q.src     <= USP_SRC_ONBOARD;
      q.led_oe_n  <= 1'b1;
      q.full_oe_n <= 1'b1;
      q.low_oe_n  <= 1'b1;
      q.pu_oe_n   <= 1'b1;
      q.ata_oe_n  <= 1'b1;
      q.waitreq   <= 1'b1;
      q.enum_ctl  <= 1'b1;
      q.low_ctl   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign avs_readdata              = q.rdata;
  assign avs_waitrequest           = q.waitreq;
  assign led_out                   = 1'b0;
  assign led_oe_n                  = q.led_oe_n;
  assign full_bus_power_grant_n    = 1'b0;
  assign full_bus_power_grant_oe_n = q.full_oe_n;
  assign low_bus_power_avail       = 1'b1;
  assign low_bus_power_avail_oe_n  = q.low_oe_n;
  assign usb_enum_pwr              = q.enum_pwr;
  assign flow_ctl_pullup_drive     = 1'b1;
  assign flow_ctl_pullup_oe_n      = q.pu_oe_n;
  assign ata_out_oe_n              = q.ata_oe_n;
  assign usb_if_enable             = q.usb_en;
  assign drive_bus_powered         = q.bus_powered;
  assign cfg_source                = q.src;

endmodule

// ### tb/usp_status_power_chk.sv
// Port checks for the status and power indicator block
`timescale 1ns/1ps
module usp_status_power_chk
  import usp_pkg::*;
#(parameter int unsigned BLINK_HALF_CYC = 8) (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [7:0] usb_config_value,
  input wire logic       usb_suspended,
  input wire logic       drive_bus_share_enable,
  input wire logic       bus_power_in,
  input wire logic       probe_done,
  input wire logic       led_oe_n,
  input wire logic       full_bus_power_grant_oe_n,
  input wire logic       ata_out_oe_n,
  input wire logic       usb_if_enable,
  input wire logic       usb_enum_pwr,
  input wire logic       drive_bus_powered,
  input wire usp_src_e   cfg_source
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence idle0; usb_config_value == 8'h00 && !usb_suspended; endsequence
  sequence run1; usb_config_value != 8'h00 && !usb_suspended; endsequence
  led_blink_a: assert property (idle0 [*8] |-> ##[0:9] ($changed(led_oe_n) || usb_config_value != 8'h00 || usb_suspended))
    else $error("led not blinking");
  led_lit_a: assert property (run1 |=> !led_oe_n) else $error("led not lit");
  led_off_a: assert property (usb_suspended |=> led_oe_n) else $error("led not off");
  full_grant_a: assert property (1'b1 |=> full_bus_power_grant_oe_n == ($past(usb_config_value) == 8'h00))
    else $error("grant wrong");
  share_on_a: assert property (drive_bus_share_enable |=> !ata_out_oe_n && usb_if_enable)
    else $error("share on wrong");
  share_off_a: assert property (!drive_bus_share_enable |=> ata_out_oe_n && !usb_if_enable && !usb_enum_pwr)
    else $error("share off wrong");
  bus_pwr_a: assert property (1'b1 |=> drive_bus_powered == $past(bus_power_in)) else $error("power src");
  src_hold_a: assert property (probe_done ##1 1'b1 |=> $stable(cfg_source)) else $error("source moved");
endmodule
bind usp_status_power usp_status_power_chk #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) chk (.*);

// ### tb/usp_far_side.sv
// Host, board and drive levels seen by the block
`timescale 1ns/1ps
module usp_far_side (
  input  wire logic  clk,
  output logic [7:0] usb_config_value,
  output logic       usb_suspended,
  output logic       drive_bus_share_enable,
  output logic       bus_power_in,
  output logic       drive_cfg_mode,
  output logic       serial_mem_present,
  output logic       serial_sig_ok,
  output logic       probe_done
);
  // Sharing enable and bus power rest high through pull-ups
  initial {usb_config_value, usb_suspended, drive_bus_share_enable, bus_power_in} = 11'h003;
  initial {drive_cfg_mode, serial_mem_present, serial_sig_ok, probe_done} = 4'h0;
  task automatic lines(logic [7:0] cfg, logic susp, logic share, logic bpwr);
    @(posedge clk);
    {usb_config_value, usb_suspended, drive_bus_share_enable, bus_power_in} <= {cfg, susp, share, bpwr};
  endtask
  // Probe result of a memory of at most 4 Kbytes; drive answers identify under low power
  task automatic probe(logic [2:0] psm);
    @(posedge clk);
    {serial_mem_present, serial_sig_ok, drive_cfg_mode, probe_done} <= {psm, 1'b1};
    @(posedge clk);
    probe_done <= 1'b0;
  endtask
endmodule

// ### tb/usp_status_power_tb.sv
// Self-checking bench for the status and power indicator block
`timescale 1ns/1ps
module usp_status_power_tb;
  import usp_pkg::*;
  logic clk = 0, rstn = 0, avs_read = 0, avs_write = 0, last, avs_waitrequest, probe_done;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, seen;
  logic [7:0] usb_config_value;
  logic usb_suspended, drive_bus_share_enable, bus_power_in, drive_cfg_mode, serial_mem_present, serial_sig_ok;
  logic led_out, led_oe_n, full_bus_power_grant_n, full_bus_power_grant_oe_n, low_bus_power_avail;
  logic low_bus_power_avail_oe_n, usb_enum_pwr, flow_ctl_pullup_drive, flow_ctl_pullup_oe_n;
  logic ata_out_oe_n, usb_if_enable, drive_bus_powered;
  usp_src_e cfg_source;
  int fail_count = 0, checks_done = 0, cyc = 0, tog;
  logic [2:0] prb [3] = '{3'b110, 3'b100, 3'b001};
  usp_src_e want [3] = '{USP_SRC_SERIAL, USP_SRC_ONBOARD, USP_SRC_DRIVE};
  usp_status_power #(.BLINK_HALF_CYC(8)) uut (.*);
  usp_far_side far (.*);
  initial forever #12.5 clk = ~clk;
  task automatic print_verdict();
    if (fail_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 20000) begin
    fail_count++;
    print_verdict();
  end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    {avs_address, avs_writedata, avs_read, avs_write} <= {a, d, !wr, wr};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    seen = avs_readdata;
    {avs_read, avs_write} <= 2'b00;
  endtask
  initial begin
    for (int i = 0; i < 3; i++) begin
      rstn <= 0;
      step(12);
      rstn <= 1;
      far.probe(prb[i]);
      step(2);
      chk("source", want[i], cfg_source);
      far.probe(prb[(i + 1) % 3]);
      step(2);
      chk("source held", want[i], cfg_source);
    end
    bus(0, 4'h2, 0); chk("id", 32'h0000_A5C3, seen);
    bus(0, 4'h0, 0); chk("ctrl reset", 32'h0000_0005, seen);
    bus(1, 4'h3, 32'hFFFF_FFFF);
    bus(0, 4'h3, 0); chk("unmapped", 32'h0, seen);
    far.lines(8'h00, 0, 1, 1); step(3);
    chk("grant idle", 1, full_bus_power_grant_oe_n);
    tog = 0;
    last = led_oe_n;
    repeat (32) begin
      @(posedge clk);
      if (led_oe_n !== last) tog++;
      last = led_oe_n;
    end
    chk("blink toggles", 4, tog);
    far.lines(8'h01, 0, 1, 1); step(3);
    chk("lit and grant", 2'b00, {led_oe_n, full_bus_power_grant_oe_n});
    chk("low power on", 1'b0, low_bus_power_avail_oe_n);
    far.lines(8'h01, 1, 0, 0); step(3);
    chk("led off", 1, led_oe_n);
    chk("share off", 4'b1000, {ata_out_oe_n, usb_if_enable, usb_enum_pwr, drive_bus_powered});
    far.lines(8'h01, 0, 1, 1); step(3);
    chk("share on", 4'b0111, {ata_out_oe_n, usb_if_enable, usb_enum_pwr, drive_bus_powered});
    bus(1, 4'h0, 32'h2); step(2);
    chk("ctrl pins", 3'b001, {usb_enum_pwr, flow_ctl_pullup_oe_n, low_bus_power_avail_oe_n});
    chk("pin levels", 4'b0011, {led_out, full_bus_power_grant_n, low_bus_power_avail, flow_ctl_pullup_drive});
    print_verdict();
  end
endmodule
